// ===== rtl/pcs_status_defines.svh
// Functional notes
// - Status bits 15 to 9 always read zero: no 100 Mb/s or 10 Mb/s abilities.
// - Status bit 8 always reads one: extended status register 15 exists.
// - Status bit 7 always reads one (unidirectional ability); writes to it ignored.
// - With auto-negotiation, bit 5 reads one once negotiation has finished.
// - With auto-negotiation, bit 4 sets on remote fault, clears on read; else zero.
// - With auto-negotiation, bit 3 always reads one: device can auto-negotiate.
// - Bit 2 latches zero when link drops, holds until read, then reloads the present link state.
// - Link bit is one only with sync, transceiver reset done and, if negotiation is enabled, negotiation done.
// - Link bit is zero on sync failure, incomplete negotiation while enabled, or sync loss since read.
// - On sync loss, link drops only after sync stays lost for one full link timer period.
`ifndef PCS_STATUS_DEFINES_SVH
`define PCS_STATUS_DEFINES_SVH

// register index of the status register on the management interface
`define STATUS_REG_INDEX     5'h01

// field positions inside the status word
`define STAT_EXT_STATUS_BIT  8
`define STAT_UNIDIR_BIT      7
`define STAT_PREAMBLE_BIT    6
`define STAT_AN_DONE_BIT     5
`define STAT_FAULT_BIT       4
`define STAT_AN_ABLE_BIT     3
`define STAT_LINK_BIT        2

// base value of the status word before the fixed and tracked bits are set
`define STAT_RESET_WORD      16'h0000

// management frame codes
`define MGMT_OP_READ         2'h2
`define MGMT_OP_WRITE        2'h1

// last bit index of the address and data fields in a management frame
`define MGMT_ADDR_LAST       5'h09
`define MGMT_DATA_LAST       5'h0F

// timing: core clock period and link timer length
`define CLK_PERIOD_NS        50
`define LINK_TIMER_US        10000
`define LINK_TIMER_CYCLES    ((`LINK_TIMER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/pcs_status_pkg.sv
package pcs_status_pkg;

  // management frame receiver states
  typedef enum logic [2:0] {
    MGMT_IDLE   = 3'b000,
    MGMT_START  = 3'b001,
    MGMT_OPCODE = 3'b010,
    MGMT_ADDR   = 3'b011,
    MGMT_TURN   = 3'b100,
    MGMT_DATA   = 3'b101
  } mgmt_state_type;

  // state of the frame receiver and pin driver
  typedef struct packed {
    logic           mdc_meta;
    logic           mdc_sync;
    logic           mdc_prev;
    logic           mdio_meta;
    logic           mdio_sync;
    mgmt_state_type state;
    logic [4:0]     cnt;
    logic           op_high;
    logic           op_read;
    logic [9:0]     addr;
    logic           go_read;
    logic [15:0]    tx_shift;
    logic           pin_out;
    logic           pin_oe;
    logic           rd_pulse;
  } frame_state_type;

  // state of the link and fault tracking
  typedef struct packed {
    logic [31:0] loss_timer;
    logic        sync_held;
    logic        link_latched;
    logic        fault_latched;
  } monitor_state_type;

endpackage

// ===== rtl/status_link_if.sv
`timescale 1ns/1ps
interface status_link_if;
  logic rd_pulse;      // one-cycle pulse when the status word is captured
  logic link_bit;      // latched-low link status
  logic fault_bit;     // sticky remote fault
  logic an_done_bit;   // negotiation finished

  modport reg_side (
    output rd_pulse,
    input  link_bit,
    input  fault_bit,
    input  an_done_bit
  );

  modport mon_side (
    input  rd_pulse,
    output link_bit,
    output fault_bit,
    output an_done_bit
  );
endinterface // status_link_if

// ===== rtl/link_status_monitor.sv
`timescale 1ns/1ps
`include "pcs_status_defines.svh"
module link_status_monitor
  import pcs_status_pkg::*;
#(
  parameter bit HAS_AUTONEG       = 1'b1,
  parameter int LINK_TIMER_CYCLES = `LINK_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // core status, same clock domain
  input  wire logic  sync_ok,
  input  wire logic  an_enable,
  input  wire logic  an_complete,
  input  wire logic  fault_event,
  input  wire logic  xcvr_done,
  // register side
  status_link_if.mon_side st
);

  monitor_state_type cur;
  monitor_state_type next_cur;
  logic              link_now;

  ////////////////////////////////////////////////////////////////////////////
  // present link condition
  always_comb begin
    link_now = cur.sync_held && (!an_enable || an_complete) && xcvr_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: loss timer, latched link, sticky fault
  always_comb begin
    next_cur = cur;
    // sync loss is filtered so a short glitch cannot take the link down
    if (sync_ok) begin
      next_cur.loss_timer = 32'h0000_0000;
      next_cur.sync_held  = 1'b1;
    end else if (cur.sync_held) begin
      next_cur.loss_timer = cur.loss_timer + 32'h0000_0001;
      if (cur.loss_timer >= 32'(LINK_TIMER_CYCLES - 1)) begin
        next_cur.sync_held = 1'b0;
      end
    end
    // a read reloads the present state, otherwise the bit only falls
    if (st.rd_pulse) begin
      next_cur.link_latched = link_now;
    end else if (!link_now) begin
      next_cur.link_latched = 1'b0;
    end
    // a fault arriving in the read cycle survives the clear
    if (!HAS_AUTONEG) begin
      next_cur.fault_latched = 1'b0;
    end else if (fault_event) begin
      next_cur.fault_latched = 1'b1;
    end else if (st.rd_pulse) begin
      next_cur.fault_latched = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the register side
  assign st.link_bit    = cur.link_latched;
  assign st.fault_bit   = cur.fault_latched;
  assign st.an_done_bit = HAS_AUTONEG && an_complete;

endmodule // link_status_monitor

// ===== rtl/pcs_status_register.sv
`timescale 1ns/1ps
`include "pcs_status_defines.svh"
module pcs_status_register
  import pcs_status_pkg::*;
#(
  parameter bit HAS_AUTONEG       = 1'b1,
  parameter int LINK_TIMER_CYCLES = `LINK_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  // management interface pins
  input  wire logic       MDC,
  input  wire logic       MDIO_IN,
  output logic            MDIO_OUT,
  output logic            MDIO_OE,
  // device address on the management bus
  input  wire logic [4:0] PHY_ADDR,
  // core status inputs
  input  wire logic       SYNC_OK,
  input  wire logic       AN_ENABLE,
  input  wire logic       AN_COMPLETE,
  input  wire logic       REMOTE_FAULT_EVENT,
  input  wire logic       XCVR_RESET_DONE
);

  frame_state_type cur;
  frame_state_type next_cur;
  logic            mdc_rise;
  logic            bit_in;
  status_link_if   st ();

  ////////////////////////////////////////////////////////////////////////////
  // assemble the status word from constants and tracked state
  function automatic logic [15:0] status_word(input logic link, input logic fault, input logic an_done);
    logic [15:0] w;
    w = `STAT_RESET_WORD;
    w[`STAT_EXT_STATUS_BIT] = 1'b1;
    w[`STAT_UNIDIR_BIT]     = 1'b1;
    w[`STAT_PREAMBLE_BIT]   = 1'b1;
    w[`STAT_AN_DONE_BIT]    = an_done;
    w[`STAT_FAULT_BIT]      = fault;
    w[`STAT_AN_ABLE_BIT]    = HAS_AUTONEG;
    w[`STAT_LINK_BIT]       = link;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link and fault tracking
  link_status_monitor #(
    .HAS_AUTONEG       (HAS_AUTONEG),
    .LINK_TIMER_CYCLES (LINK_TIMER_CYCLES)
  ) u_monitor (
    .clk         (MCLK),
    .rst_n       (RSTN),
    .sync_ok     (SYNC_OK),
    .an_enable   (AN_ENABLE),
    .an_complete (AN_COMPLETE),
    .fault_event (REMOTE_FAULT_EVENT),
    .xcvr_done   (XCVR_RESET_DONE),
    .st          (st.mon_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge and data from the synchronised pins; the first stage feeds only the second
  assign mdc_rise = cur.mdc_sync && !cur.mdc_prev;
  assign bit_in   = cur.mdio_sync;

  ////////////////////////////////////////////////////////////////////////////
  // frame receiver: every step happens on a sampled rising edge of the bus clock
  always_comb begin
    next_cur           = cur;
    next_cur.mdc_meta  = MDC;
    next_cur.mdc_sync  = cur.mdc_meta;
    next_cur.mdc_prev  = cur.mdc_sync;
    next_cur.mdio_meta = MDIO_IN;
    next_cur.mdio_sync = cur.mdio_meta;
    next_cur.rd_pulse  = 1'b0;
    if (mdc_rise) begin
      unique case (cur.state)
        // idle line is high; a low bit opens a frame, preamble or not
        MGMT_IDLE: begin
          if (!bit_in) begin
            next_cur.state = MGMT_START;
          end
        end
        MGMT_START: begin
          next_cur.cnt   = 5'h00;
          next_cur.state = bit_in ? MGMT_OPCODE : MGMT_IDLE;
        end
        MGMT_OPCODE: begin
          if (cur.cnt == 5'h00) begin
            next_cur.op_high = bit_in;
            next_cur.cnt     = 5'h01;
          end else begin
            next_cur.op_read = ({cur.op_high, bit_in} == `MGMT_OP_READ);
            next_cur.cnt     = 5'h00;
            if ({cur.op_high, bit_in} == `MGMT_OP_READ || {cur.op_high, bit_in} == `MGMT_OP_WRITE) begin
              next_cur.state = MGMT_ADDR;
            end else begin
              next_cur.state = MGMT_IDLE;
            end
          end
        end
        // device address then register index, most significant bit first
        MGMT_ADDR: begin
          next_cur.addr = {cur.addr[8:0], bit_in};
          next_cur.cnt  = cur.cnt + 5'h01;
          if (cur.cnt == `MGMT_ADDR_LAST) begin
            next_cur.cnt     = 5'h00;
            next_cur.state   = MGMT_TURN;
            next_cur.go_read = cur.op_read && (cur.addr[8:4] == PHY_ADDR)
                               && ({cur.addr[3:0], bit_in} == `STATUS_REG_INDEX);
          end
        end
        // turnaround: drive zero in its second half, capture the word once
        MGMT_TURN: begin
          if (cur.cnt == 5'h00) begin
            next_cur.cnt = 5'h01;
            if (cur.go_read) begin
              next_cur.pin_oe   = 1'b1;
              next_cur.pin_out  = 1'b0;
              next_cur.rd_pulse = 1'b1;
              next_cur.tx_shift = status_word(st.link_bit, st.fault_bit, st.an_done_bit);
            end
          end else begin
            next_cur.cnt   = 5'h00;
            next_cur.state = MGMT_DATA;
            if (cur.go_read) begin
              next_cur.pin_out  = cur.tx_shift[15];
              next_cur.tx_shift = {cur.tx_shift[14:0], 1'b0};
            end
          end
        end
        // sixteen data bits: shifted out on a read, swallowed on a write
        MGMT_DATA: begin
          next_cur.cnt = cur.cnt + 5'h01;
          if (cur.cnt == `MGMT_DATA_LAST) begin
            next_cur.pin_oe  = 1'b0;
            next_cur.pin_out = 1'b0;
            next_cur.state   = MGMT_IDLE;
          end else if (cur.go_read) begin
            next_cur.pin_out  = cur.tx_shift[15];
            next_cur.tx_shift = {cur.tx_shift[14:0], 1'b0};
          end
          // write data is never stored, so a write alters no bit
        end
        default: begin
          next_cur.state  = MGMT_IDLE;
          next_cur.pin_oe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign st.rd_pulse = cur.rd_pulse;
  assign MDIO_OUT    = cur.pin_out;
  assign MDIO_OE     = cur.pin_oe;

endmodule // pcs_status_register

// ===== test/pcs_status_checker.sv
`timescale 1ns/1ps
module pcs_status_checker #(
  parameter bit HAS_AUTONEG = 1'b1
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // pins and status watched
  input wire logic MDC,
  input wire logic MDIO_OUT,
  input wire logic MDIO_OE,
  input wire logic AN_COMPLETE,
  input wire logic REMOTE_FAULT_EVENT
);
  logic       mdc_q;
  logic       oe_q;
  logic       flt;
  logic       f_cap;
  logic [4:0] cnt;
  logic       smp;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////
  // count mdc rises while answering; the turnaround rise precedes oe
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      {mdc_q, oe_q, flt, f_cap, cnt} <= '0;
    end else begin
      mdc_q <= MDC;
      oe_q  <= MDIO_OE;
      cnt   <= !MDIO_OE ? 5'h00 : cnt + 5'(MDC & !mdc_q);
      // the word is taken before this edge's event lands; the event survives the clear
      if (MDIO_OE & !oe_q) begin
        f_cap <= flt;
        flt   <= REMOTE_FAULT_EVENT;
      end else begin
        flt <= flt | REMOTE_FAULT_EVENT;
      end
    end
  end
  // sample mid-bit, where the wire is settled
  assign smp = mdc_q & !MDC & MDIO_OE;
  property bit_is(int k, logic v);
    smp && cnt == k |-> MDIO_OUT == v;
  endproperty
  ////////////////////////////////////////////////////////////////////////
  a_ta_low: assert property (bit_is(0, 1'b0)) else $error("turnaround bit not low");
  a_high_zero: assert property (smp && cnt inside {[1:7]} |-> !MDIO_OUT) else $error("bits 15..9 not zero");
  a_ext_one: assert property (bit_is(8, 1'b1)) else $error("bit 8 not one");
  a_unidir_one: assert property (bit_is(9, 1'b1)) else $error("bit 7 not one");
  a_pre_one: assert property (bit_is(10, 1'b1)) else $error("bit 6 not one");
  a_an_done: assert property (bit_is(11, AN_COMPLETE & HAS_AUTONEG)) else $error("bit 5 wrong");
  a_fault_flag: assert property (bit_is(12, f_cap & HAS_AUTONEG)) else $error("bit 4 wrong");
  a_an_able: assert property (bit_is(13, HAS_AUTONEG)) else $error("bit 3 wrong");
  a_low_zero: assert property (smp && cnt >= 15 |-> !MDIO_OUT) else $error("bits 1..0 not zero");
  a_word_len: assert property ($fell(MDIO_OE) |-> cnt == 17) else $error("answer length wrong");
  cover property (smp && cnt == 14 && MDIO_OUT);
  cover property (smp && cnt == 12 && MDIO_OUT);
  cover property ($fell(MDIO_OE));
endmodule // pcs_status_checker

// ===== test/mgmt_host_model.sv
`timescale 1ns/1ps
module mgmt_host_model #(
  parameter int HALF = 8
) (
  // clock
  input  wire logic MCLK,
  // management wire
  input  wire logic mdi,
  output logic      mdc,
  output logic      mdo,
  output logic      moe
);
  initial begin
    {mdc, mdo, moe} = 3'b010;
  end
  ////////////////////////////////////////////////////////////////////////
  // one bit: drive on the low phase, sample the wire at the rise
  task automatic slot(input logic d, en, inout logic [15:0] sh);
    @(posedge MCLK) #1 {mdc, mdo, moe} = {1'b0, d, en};
    repeat (HALF) @(posedge MCLK);
    #1 mdc = 1'b1;
    sh = {sh[14:0], mdi};
    repeat (HALF - 1) @(posedge MCLK);
  endtask
  // whole frame; a read releases the wire from the turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [31:0] hdr;
    logic [15:0] sh;
    hdr = {2'b01, op, pa, ra, 2'b10, wd};
    sh = 16'h0000;
    repeat (2) slot(1'b1, 1'b1, sh);
    for (int i = 31; i >= 0; i--) slot(hdr[i], (op == 2'b01) || (i > 17), sh);
    rd = sh;
    slot(1'b1, 1'b0, sh);
  endtask
endmodule // mgmt_host_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int         TMR = 8;
  localparam logic [4:0] PA  = 5'h05;
  logic        mclk, rstn, sync_ok, an_en, an_c, xcvr, fault_ev;
  logic        mdio_out, mdio_oe, mdc, mdo, moe, mdio;
  logic [15:0] got;
  int          bad_count, n_compared, cycles;
  // pull-up wire: released by both reads as one
  assign mdio = mdio_oe ? mdio_out : (moe ? mdo : 1'b1);
  pcs_status_register #(.LINK_TIMER_CYCLES(TMR)) u_pcs_status_register (
    .MCLK(mclk), .RSTN(rstn), .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
    .PHY_ADDR(PA), .SYNC_OK(sync_ok), .AN_ENABLE(an_en), .AN_COMPLETE(an_c),
    .REMOTE_FAULT_EVENT(fault_ev), .XCVR_RESET_DONE(xcvr));
  mgmt_host_model u_mgmt_host_model (.MCLK(mclk), .mdi(mdio), .mdc(mdc), .mdo(mdo), .moe(moe));
  ////////////////////////////////////////////////////////////////////////
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  // a frame is about 560 cycles, so this leaves ample margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d, failed %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic set_in(input logic [4:0] v);
    @(posedge mclk) #1 {sync_ok, an_en, an_c, xcvr, fault_ev} = v;
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    u_mgmt_host_model.frame(2'b10, PA, ra, 16'h0000, got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED status word exp %h got %h", exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, sync_ok, an_en, an_c, xcvr, fault_ev} = 6'b011110;
    repeat (2) @(posedge mclk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge mclk);
    rd(5'h01, 16'h01E8);
    rd(5'h01, 16'h01EC);
    set_in(5'b11010);
    rd(5'h01, 16'h01C8);
    set_in(5'b11110);
    rd(5'h01, 16'h01E8);
    rd(5'h01, 16'h01EC);
    set_in(5'b10010);
    rd(5'h01, 16'h01CC);
    set_in(5'b10000);
    set_in(5'b10010);
    rd(5'h01, 16'h01C8);
    rd(5'h01, 16'h01CC);
    set_in(5'b00010);
    repeat (TMR - 2) @(posedge mclk);
    set_in(5'b10010);
    rd(5'h01, 16'h01CC);
    set_in(5'b00010);
    repeat (TMR + 2) @(posedge mclk);
    set_in(5'b10010);
    rd(5'h01, 16'h01C8);
    rd(5'h01, 16'h01CC);
    set_in(5'b11110);
    rd(5'h01, 16'h01EC);
    set_in(5'b11111);
    set_in(5'b11110);
    u_mgmt_host_model.frame(2'b01, PA, 5'h01, 16'h0000, got);
    rd(5'h01, 16'h01FC);
    rd(5'h01, 16'h01EC);
    rd(5'h02, 16'hFFFF);
    results();
  end
endmodule // tb
bind pcs_status_register pcs_status_checker #(.HAS_AUTONEG(HAS_AUTONEG)) u_pcs_status_checker (
  .MCLK(MCLK), .RSTN(RSTN), .MDC(MDC), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE),
  .AN_COMPLETE(AN_COMPLETE), .REMOTE_FAULT_EVENT(REMOTE_FAULT_EVENT));
